/* common/i2cis_pkg.sv */
// Constants shared by the two-wire interrupt status block
package i2cis_pkg;

   // -------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------
   localparam logic [31:0] OFF_MSTAT    = 32'h5000142C;
   localparam logic [31:0] OFF_MASK     = 32'h50001430;
   localparam logic [31:0] OFF_RAW      = 32'h50001434;
   localparam logic [31:0] OFF_ENABLE   = 32'h50001440;
   localparam logic [31:0] OFF_DATA     = 32'h50001444;
   localparam logic [31:0] OFF_TX_TL    = 32'h50001448;
   localparam logic [31:0] OFF_RECEIVE_THRESHOLD    = 32'h5000144C;
   localparam logic [31:0] OFF_CLR_ALL  = 32'h50001450;
   localparam logic [31:0] OFF_CLR_GC   = 32'h50001454;
   localparam logic [31:0] OFF_CLR_ACT  = 32'h50001458;
   localparam logic [31:0] OFF_CLR_ABRT = 32'h5000145C;
   localparam logic [31:0] OFF_CLR_RD   = 32'h50001460;
   localparam logic [31:0] OFF_ABRT_SRC = 32'h50001464;
   localparam logic [31:0] OFF_SADDR    = 32'h50001468;

   // -------------------------------------------------------------
   // Status bit positions
   // -------------------------------------------------------------
   localparam int unsigned B_GEN_CALL = 11;
   localparam int unsigned B_START    = 10;
   localparam int unsigned B_STOP     = 9;
   localparam int unsigned B_ACTIVITY = 8;
   localparam int unsigned B_TX_DONE  = 7;
   localparam int unsigned B_TX_ABRT  = 6;
   localparam int unsigned B_RD_REQ   = 5;
   localparam int unsigned B_TX_EMPTY = 4;
   localparam int unsigned B_TX_OVER  = 3;
   localparam int unsigned B_RX_FULL  = 2;
   localparam int unsigned B_RX_OVER  = 1;
   localparam int unsigned B_RX_UNDER = 0;
   localparam int unsigned FLAG_W     = 12;

   // -------------------------------------------------------------
   // Reset values and sizes
   // -------------------------------------------------------------
   localparam logic [11:0] MASK_RST   = 12'h8FF;
   localparam logic [6:0]  SADDR_RST  = 7'h10;
   localparam int unsigned TL_RST     = 0;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned B_ENABLE   = 0;
   localparam int unsigned B_SRC_SLV  = 0;

endpackage : i2cis_pkg

/* core/i2cis_core.sv */
// Two-wire controller interrupt status, FIFOs and register port
//
// Summary of operation
// - General-call flag sets on acknowledged general call; clears on disable or clear read.
// - Data bytes after an acknowledged general call go into the receive FIFO.
// - Start-detect flag sets on every START or repeated START, any role.
// - Stop-detect flag sets on every STOP condition, any role.
// - Activity flag latches; clears on disable, activity or combined clear read, reset.
// - Transmit-done flag sets when master does not acknowledge a slave-sent byte.
// - Transmit-abort flag sets on failed transmit; abort cause records why.
// - Abort flushes transmit FIFO, which refuses data until abort clear read.
// - Read request from remote master sets flag and holds clock low.
// - Software answers by writing data; read-request clear read drops the flag.
// - Transmit-empty high while transmit level is at or below threshold.
// - Disabled: transmit FIFO flushed; transmit-empty follows state machine activity.
// - Transmit-overflow sets on data write while transmit FIFO holds 32 entries.
// - Overflow and underflow flags clear once internal enable falls.
// - Receive-full high while receive level reaches or exceeds threshold.
// - Disable flushes receive FIFO and clears receive-full at once.
// - Byte arriving at full receive FIFO is acknowledged, dropped, flags overflow.
// - Receive-underflow sets on data read from an empty receive FIFO.
// - Masked status shows each raw flag only where its mask bit is set.
`timescale 1ns/1ps
module i2cis_core #(
   parameter int unsigned DEPTH     = i2cis_pkg::FIFO_DEPTH,
   parameter logic [6:0]  SADDR_DEF = i2cis_pkg::SADDR_RST
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Peripheral bus
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Bus pins
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o
);

   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned LW = PW + 1;
   localparam int unsigned FW = i2cis_pkg::FLAG_W;
   localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

   function automatic logic i2cis_hit(input logic [31:0] a,
                                      input logic [31:0] o);
      return (a == o);
   endfunction : i2cis_hit

   // -------------------------------------------------------------
   // Register port decode
   // -------------------------------------------------------------
   wire setup = psel_i & ~penable_i;
   wire acc   = psel_i & penable_i;
   wire wr    = acc & pwrite_i;
   wire rd    = acc & ~pwrite_i;

   wire h_mstat = i2cis_hit(paddr_i, i2cis_pkg::OFF_MSTAT);
   wire h_mask  = i2cis_hit(paddr_i, i2cis_pkg::OFF_MASK);
   wire h_raw   = i2cis_hit(paddr_i, i2cis_pkg::OFF_RAW);
   wire h_en    = i2cis_hit(paddr_i, i2cis_pkg::OFF_ENABLE);
   wire h_data  = i2cis_hit(paddr_i, i2cis_pkg::OFF_DATA);
   wire h_txtl  = i2cis_hit(paddr_i, i2cis_pkg::OFF_TX_TL);
   wire h_rxtl  = i2cis_hit(paddr_i, i2cis_pkg::OFF_RECEIVE_THRESHOLD);
   wire h_call  = i2cis_hit(paddr_i, i2cis_pkg::OFF_CLR_ALL);
   wire h_cgc   = i2cis_hit(paddr_i, i2cis_pkg::OFF_CLR_GC);
   wire h_cact  = i2cis_hit(paddr_i, i2cis_pkg::OFF_CLR_ACT);
   wire h_cabrt = i2cis_hit(paddr_i, i2cis_pkg::OFF_CLR_ABRT);
   wire h_crd   = i2cis_hit(paddr_i, i2cis_pkg::OFF_CLR_RD);
   wire h_src   = i2cis_hit(paddr_i, i2cis_pkg::OFF_ABRT_SRC);
   wire h_saddr = i2cis_hit(paddr_i, i2cis_pkg::OFF_SADDR);
   wire mapped  = h_mstat | h_mask | h_raw | h_en | h_data | h_txtl
                | h_rxtl | h_call | h_cgc | h_cact | h_cabrt | h_crd
                | h_src | h_saddr;

   // Only clear and data reads carry side effects
   wire clr_all  = rd & h_call;
   wire clr_gc   = rd & h_cgc;
   wire clr_act  = rd & h_cact;
   wire clr_abrt = rd & h_cabrt;
   wire clr_rd   = rd & h_crd;

   assign pready_o  = 1'b1;
   assign pslverr_o = acc & ~mapped;

   // -------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------
   logic [11:0]   mask_q;
   logic          en_q;
   logic          internal_enable_q;
   logic [PW-1:0] tx_tl_q;
   logic [PW-1:0] receive_threshold_q;
   logic [6:0]    saddr_q;
   logic          link_busy;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mask_q  <= i2cis_pkg::MASK_RST;
         en_q    <= 1'b0;
         tx_tl_q <= PW'(i2cis_pkg::TL_RST);
         receive_threshold_q <= PW'(i2cis_pkg::TL_RST);
         saddr_q <= SADDR_DEF;
      end else if (wr) begin
         if (h_mask)  mask_q  <= pwdata_i[11:0];
         if (h_en)    en_q    <= pwdata_i[i2cis_pkg::B_ENABLE];
         if (h_txtl)  tx_tl_q <= pwdata_i[PW-1:0];
         if (h_rxtl)  receive_threshold_q <= pwdata_i[PW-1:0];
         if (h_saddr) saddr_q <= pwdata_i[6:0];
      end
   end

   // Internal enable falls only once the state machine is idle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) internal_enable_q <= 1'b0;
      else           internal_enable_q <= en_q | (internal_enable_q & link_busy);
   end

   // -------------------------------------------------------------
   // Link engine
   // -------------------------------------------------------------
   logic       tx_valid;
   logic [7:0] tx_head;
   logic       ev_start, ev_stop, ev_gc, ev_addr_rd, ev_need, ev_nack;
   logic       rx_valid;
   logic [7:0] rx_byte;
   logic       tx_pop;

   i2cis_link u_link (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .scl_oe_o   (scl_oe_o),
      .sda_oe_o   (sda_oe_o),
      .en_i       (en_q),
      .own_addr_i (saddr_q),
      .tx_valid_i (tx_valid),
      .tx_data_i  (tx_head),
      .start_o    (ev_start),
      .stop_o     (ev_stop),
      .gcall_o    (ev_gc),
      .addr_rd_o  (ev_addr_rd),
      .need_o     (ev_need),
      .nack_o     (ev_nack),
      .rx_valid_o (rx_valid),
      .rx_data_o  (rx_byte),
      .tx_pop_o   (tx_pop),
      .busy_o     (link_busy)
   );

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   // -------------------------------------------------------------
   // Transmit FIFO
   // -------------------------------------------------------------
   logic [7:0]    tx_mem [DEPTH];
   logic [PW-1:0] tx_wp_q, tx_rp_q;
   logic [LW-1:0] tx_lvl_q;
   logic [FW-1:0] flag_q;

   wire tx_full  = (tx_lvl_q == FULL_LVL);
   wire tx_none  = (tx_lvl_q == '0);
   wire abrt_ev  = ev_addr_rd & ~tx_none;
   wire tx_lock  = flag_q[i2cis_pkg::B_TX_ABRT];
   wire tx_flush = ~en_q | tx_lock | abrt_ev;
   wire tx_push  = wr & h_data & ~tx_flush & ~tx_full;
   wire tx_take  = tx_pop & ~tx_flush;

   assign tx_valid = ~tx_none & ~tx_flush;
   assign tx_head  = tx_mem[tx_rp_q];

   always_ff @(posedge clk_i) begin
      if (tx_push) tx_mem[tx_wp_q] <= pwdata_i[7:0];
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_wp_q  <= '0;
         tx_rp_q  <= '0;
         tx_lvl_q <= '0;
      end else if (tx_flush) begin
         tx_wp_q  <= '0;
         tx_rp_q  <= '0;
         tx_lvl_q <= '0;
      end else begin
         tx_wp_q  <= tx_wp_q + PW'(tx_push);
         tx_rp_q  <= tx_rp_q + PW'(tx_take);
         tx_lvl_q <= tx_lvl_q + LW'(tx_push) - LW'(tx_take);
      end
   end

   // -------------------------------------------------------------
   // Receive FIFO
   // -------------------------------------------------------------
   logic [7:0]    rx_mem [DEPTH];
   logic [PW-1:0] rx_wp_q, rx_rp_q;
   logic [LW-1:0] rx_lvl_q;

   wire rx_full = (rx_lvl_q == FULL_LVL);
   wire rx_none = (rx_lvl_q == '0);
   wire rx_push = rx_valid & en_q & ~rx_full;
   wire rx_pop  = rd & h_data & ~rx_none;

   always_ff @(posedge clk_i) begin
      if (rx_push) rx_mem[rx_wp_q] <= rx_byte;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_wp_q  <= '0;
         rx_rp_q  <= '0;
         rx_lvl_q <= '0;
      end else if (!en_q) begin
         rx_wp_q  <= '0;
         rx_rp_q  <= '0;
         rx_lvl_q <= '0;
      end else begin
         rx_wp_q  <= rx_wp_q + PW'(rx_push);
         rx_rp_q  <= rx_rp_q + PW'(rx_pop);
         rx_lvl_q <= rx_lvl_q + LW'(rx_push) - LW'(rx_pop);
      end
   end

   // -------------------------------------------------------------
   // Status flags
   // -------------------------------------------------------------
   logic [FW-1:0] set_v, clr_v, raw_v;
   logic          src_q;

   always_comb begin
      set_v = '0;
      clr_v = {FW{clr_all}};
      set_v[i2cis_pkg::B_GEN_CALL] = ev_gc;
      set_v[i2cis_pkg::B_START]    = ev_start;
      set_v[i2cis_pkg::B_STOP]     = ev_stop;
      set_v[i2cis_pkg::B_ACTIVITY] = link_busy;
      set_v[i2cis_pkg::B_TX_DONE]  = ev_nack;
      set_v[i2cis_pkg::B_TX_ABRT]  = abrt_ev;
      set_v[i2cis_pkg::B_RD_REQ]   = ev_need & (tx_none | tx_flush);
      set_v[i2cis_pkg::B_TX_OVER]  = wr & h_data & tx_full;
      set_v[i2cis_pkg::B_RX_OVER]  = rx_valid & en_q & rx_full;
      set_v[i2cis_pkg::B_RX_UNDER] = rd & h_data & rx_none;
      clr_v[i2cis_pkg::B_GEN_CALL] = clr_all | clr_gc | ~en_q;
      clr_v[i2cis_pkg::B_ACTIVITY] = clr_all | clr_act | ~en_q;
      clr_v[i2cis_pkg::B_TX_ABRT]  = clr_all | clr_abrt;
      clr_v[i2cis_pkg::B_RD_REQ]   = clr_all | clr_rd;
      clr_v[i2cis_pkg::B_TX_OVER]  = clr_all | ~internal_enable_q;
      clr_v[i2cis_pkg::B_RX_OVER]  = clr_all | ~internal_enable_q;
      clr_v[i2cis_pkg::B_RX_UNDER] = clr_all | ~internal_enable_q;
   end

   // A set arriving with its clear still wins
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) flag_q <= '0;
      else           flag_q <= (flag_q & ~clr_v) | set_v;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)    src_q <= 1'b0;
      else if (abrt_ev) src_q <= 1'b1;
      else if (clr_all | clr_abrt) src_q <= 1'b0;
   end

   wire tx_empty = en_q ? (tx_lvl_q <= LW'(tx_tl_q))
                        : link_busy;
   wire rx_thr   = en_q & (rx_lvl_q >= LW'(receive_threshold_q));

   always_comb begin
      raw_v = flag_q;
      raw_v[i2cis_pkg::B_TX_EMPTY] = tx_empty;
      raw_v[i2cis_pkg::B_RX_FULL]  = rx_thr;
   end

   // -------------------------------------------------------------
   // Read data, captured in the setup phase
   // -------------------------------------------------------------
   logic [31:0] rd_mux;
   logic [31:0] prdata_q;

   assign rd_mux =
        h_mstat ? {20'h00000, raw_v & mask_q}
      : h_raw   ? {20'h00000, raw_v}
      : h_mask  ? {20'h00000, mask_q}
      : h_en    ? {31'h00000000, en_q}
      : h_data  ? {24'h000000, rx_none ? 8'h00 : rx_mem[rx_rp_q]}
      : h_txtl  ? 32'(tx_tl_q)
      : h_rxtl  ? 32'(receive_threshold_q)
      : h_src   ? {31'h00000000, src_q}
      : h_saddr ? {25'h0000000, saddr_q}
      : 32'h00000000;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)  prdata_q <= 32'h00000000;
      else if (setup) prdata_q <= rd_mux;
   end

   assign prdata_o = prdata_q;

endmodule : i2cis_core

/* core/i2cis_link.sv */
// Two-wire slave bit engine with start and stop detection
`timescale 1ns/1ps
module i2cis_link (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_oe_o,
   output logic            sda_oe_o,
   // Control
   input  wire logic       en_i,
   input  wire logic [6:0] own_addr_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   // Events
   output logic            start_o,
   output logic            stop_o,
   output logic            gcall_o,
   output logic            addr_rd_o,
   output logic            need_o,
   output logic            nack_o,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            tx_pop_o,
   output logic            busy_o
);

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_ADDR = 7'h02,
      S_ACK  = 7'h04,
      S_RX   = 7'h08,
      S_LOAD = 7'h10,
      S_TX   = 7'h20,
      S_TACK = 7'h40
   } i2cis_lstate_t;

   i2cis_lstate_t state_q;
   logic [3:0]    cnt_q;
   logic [7:0]    sr_q;
   logic          rd_q;
   logic          ack_q;
   logic          scl_m, scl_s, scl_p;
   logic          sda_m, sda_s, sda_p;

   // -------------------------------------------------------------
   // Pin synchronisers and edge detection
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      end
   end

   wire rise    = scl_s & ~scl_p;
   wire fall    = ~scl_s & scl_p;
   wire start_c = scl_s & scl_p & sda_p & ~sda_s;
   wire stop_c  = scl_s & scl_p & ~sda_p & sda_s;
   wire byte_in = fall & (cnt_q == 4'h8);
   wire own_hit = (sr_q[7:1] == own_addr_i);
   wire gc_hit  = (sr_q == 8'h00);

   // -------------------------------------------------------------
   // Slave state machine
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= S_IDLE;
         cnt_q      <= 4'h0;
         sr_q       <= 8'h00;
         rd_q       <= 1'b0;
         ack_q      <= 1'b0;
         start_o    <= 1'b0;
         stop_o     <= 1'b0;
         gcall_o    <= 1'b0;
         addr_rd_o  <= 1'b0;
         need_o     <= 1'b0;
         nack_o     <= 1'b0;
         rx_valid_o <= 1'b0;
         tx_pop_o   <= 1'b0;
      end else begin
         start_o    <= start_c;
         stop_o     <= stop_c;
         gcall_o    <= 1'b0;
         addr_rd_o  <= 1'b0;
         need_o     <= 1'b0;
         nack_o     <= 1'b0;
         rx_valid_o <= 1'b0;
         tx_pop_o   <= 1'b0;
         if (start_c) begin
            state_q <= en_i ? S_ADDR : S_IDLE;
            cnt_q   <= 4'h0;
            ack_q   <= 1'b0;
         end else if (stop_c) begin
            state_q <= S_IDLE;
            ack_q   <= 1'b0;
         end else begin
            case (state_q)
               S_ADDR: begin
                  if (rise) begin
                     sr_q  <= {sr_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (byte_in) begin
                     if (own_hit | gc_hit) begin
                        ack_q     <= 1'b1;
                        rd_q      <= own_hit & sr_q[0];
                        gcall_o   <= gc_hit & ~own_hit;
                        addr_rd_o <= own_hit & sr_q[0];
                        state_q   <= S_ACK;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_ACK: begin
                  if (fall) begin
                     ack_q   <= 1'b0;
                     cnt_q   <= 4'h0;
                     need_o  <= rd_q;
                     state_q <= rd_q ? S_LOAD : S_RX;
                  end
               end
               S_RX: begin
                  if (rise) begin
                     sr_q  <= {sr_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (byte_in) begin
                     rx_valid_o <= 1'b1;
                     ack_q      <= 1'b1;
                     state_q    <= S_ACK;
                  end
               end
               S_LOAD: begin
                  if (tx_valid_i) begin
                     sr_q     <= tx_data_i;
                     tx_pop_o <= 1'b1;
                     cnt_q    <= 4'h0;
                     state_q  <= S_TX;
                  end
               end
               S_TX: begin
                  if (fall) begin
                     sr_q  <= {sr_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == 4'h7) begin
                        state_q <= S_TACK;
                     end
                  end
               end
               S_TACK: begin
                  if (rise && sda_s) begin
                     nack_o  <= 1'b1;
                     state_q <= S_IDLE;
                  end else if (fall) begin
                     need_o  <= 1'b1;
                     state_q <= S_LOAD;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Clock is held low while no byte is ready to send
   assign scl_oe_o  = (state_q == S_LOAD);
   assign sda_oe_o  = ack_q | ((state_q == S_TX) & ~sr_q[7]);
   assign busy_o    = (state_q != S_IDLE);
   assign rx_data_o = sr_q;

endmodule : i2cis_link

/* testbench/i2cis_core_sva.sv */
// Port-level assertions for the interrupt status core
`timescale 1ns/1ps
module i2cis_core_sva #(
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        resetn_i,
   // Peripheral bus
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // Bus pins
   input wire logic        scl_o,
   input wire logic        scl_oe_o,
   input wire logic        sda_o,
   input wire logic        sda_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic setup_rd = psel_i && !penable_i && !pwrite_i;
   chk_ready_high: assert property (pready_o)
      else $error("ready low");
   chk_err_access: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("error outside access");
   chk_err_unmapped: assert property (psel_i && penable_i &&
      paddr_i == 32'h50001500 |-> pslverr_o) else $error("no error");
   chk_stat_mapped: assert property (psel_i && penable_i &&
      paddr_i == i2cis_pkg::OFF_MSTAT |-> !pslverr_o) else $error("refused");
   chk_stat_reserved: assert property (setup_rd &&
      paddr_i == i2cis_pkg::OFF_MSTAT |=> prdata_o[31:12] == 20'h00000)
      else $error("reserved bits set");
   chk_clear_zero: assert property (setup_rd &&
      paddr_i == i2cis_pkg::OFF_CLR_RD |=> prdata_o == 32'h00000000)
      else $error("clear read nonzero");
   chk_rdata_hold: assert property (!(psel_i && !penable_i) |=>
      $stable(prdata_o)) else $error("read data moved");
   chk_pins_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("pin level high");
   chk_idle_release: assert property ($rose(resetn_i) |->
      !scl_oe_o && !sda_oe_o) else $error("pin driven at reset");
endmodule : i2cis_core_sva

/* testbench/i2cis_core_tb.sv */
// Self-checking bench for the interrupt status core
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module i2cis_core_tb;
   logic        clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0;
   logic        penable_i = 1'b0, pwrite_i = 1'b0, e, ak;
   logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, q;
   logic        pready_o, pslverr_o, scl_o, sda_o, scl_oe_o, sda_oe_o;
   logic        m_scl, m_sda;
   logic [7:0]  b;
   int          n_fail = 0, checks_done = 0, cycles = 0;
   wire logic   scl_w = !(scl_oe_o | m_scl);
   wire logic   sda_w = !(sda_oe_o | m_sda);
   always #5 clk_i = !clk_i;
   i2cis_core DUT (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_i(scl_w),
      .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o);
   i2cis_master_bfm M (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl),
      .sda_oe_o(m_sda));
   task automatic acc(input logic w, input logic [31:0] a, d);
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      q = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : acc
   task automatic raw(input logic [11:0] x);
      acc(1'b0, i2cis_pkg::OFF_RAW, 32'h0);
      `CHK(q, {20'h00000, x})
   endtask : raw
   task automatic t_reset();
      acc(1'b0, i2cis_pkg::OFF_MASK, 32'h0);
      `CHK(q, 32'h000008FF)
      acc(1'b0, i2cis_pkg::OFF_MSTAT, 32'h0);
      `CHK(q, 32'h00000000)
      raw(12'h000);
      acc(1'b0, 32'h50001500, 32'h0);
      `CHK(e, 1'b1)
   endtask : t_reset
   task automatic t_fifo();
      acc(1'b1, i2cis_pkg::OFF_MASK, 32'h00000FFF);
      acc(1'b1, i2cis_pkg::OFF_ENABLE, 32'h1);
      acc(1'b0, i2cis_pkg::OFF_DATA, 32'h0);
      raw(12'h015);
      acc(1'b1, i2cis_pkg::OFF_RECEIVE_THRESHOLD, 32'h1);
      raw(12'h011);
      acc(1'b1, i2cis_pkg::OFF_RECEIVE_THRESHOLD, 32'h0);
      for (int i = 0; i < 33; i++) acc(1'b1, i2cis_pkg::OFF_DATA, i);
      raw(12'h00D);
      acc(1'b1, i2cis_pkg::OFF_MASK, 32'h1);
      acc(1'b0, i2cis_pkg::OFF_MSTAT, 32'h0);
      `CHK(q, 32'h00000001)
      acc(1'b0, i2cis_pkg::OFF_MSTAT, 32'h0);
      `CHK(q, 32'h00000001)
      acc(1'b1, i2cis_pkg::OFF_ENABLE, 32'h0);
      // Overflow flags drop a cycle after the internal enable falls
      repeat (2) @(posedge clk_i);
      raw(12'h000);
   endtask : t_fifo
   task automatic t_gcall();
      acc(1'b1, i2cis_pkg::OFF_RECEIVE_THRESHOLD, 32'h1);
      acc(1'b1, i2cis_pkg::OFF_ENABLE, 32'h1);
      M.start_c();
      M.xfer(8'h00, b, ak);
      `CHK(ak, 1'b1)
      M.xfer(8'hA5, b, ak);
      `CHK(ak, 1'b1)
      M.stop_c();
      repeat (10) @(posedge clk_i);
      raw(12'hF14);
      acc(1'b0, i2cis_pkg::OFF_DATA, 32'h0);
      `CHK(q[7:0], 8'hA5)
      acc(1'b0, i2cis_pkg::OFF_CLR_GC, 32'h0);
      acc(1'b0, i2cis_pkg::OFF_CLR_ACT, 32'h0);
      raw(12'h610);
   endtask : t_gcall
   task automatic t_rdreq();
      acc(1'b0, i2cis_pkg::OFF_CLR_ALL, 32'h0);
      acc(1'b1, i2cis_pkg::OFF_DATA, 32'h77);
      M.start_c();
      M.xfer(8'h21, b, ak);
      `CHK(ak, 1'b1)
      fork
         M.xfer(8'hFF, b, ak);
         begin
            repeat (30) @(posedge clk_i);
            `CHK(scl_oe_o, 1'b1)
            raw(12'h570);
            acc(1'b0, i2cis_pkg::OFF_ABRT_SRC, 32'h0);
            `CHK(q, 32'h00000001)
            acc(1'b1, i2cis_pkg::OFF_DATA, 32'h99);
            raw(12'h570);
            acc(1'b0, i2cis_pkg::OFF_CLR_ABRT, 32'h0);
            acc(1'b1, i2cis_pkg::OFF_DATA, 32'h3C);
            acc(1'b0, i2cis_pkg::OFF_CLR_RD, 32'h0);
            acc(1'b0, i2cis_pkg::OFF_RAW, 32'h0);
            `CHK(q[5], 1'b0)
         end
      join
      `CHK(b, 8'h3C)
      M.stop_c();
      repeat (10) @(posedge clk_i);
      acc(1'b0, i2cis_pkg::OFF_RAW, 32'h0);
      `CHK(q[7], 1'b1)
   endtask : t_rdreq
   task automatic t_rxover();
      M.start_c();
      M.xfer(8'h20, b, ak);
      for (int i = 0; i < 33; i++) M.xfer(8'h5A, b, ak);
      `CHK(ak, 1'b1)
      M.stop_c();
      repeat (10) @(posedge clk_i);
      raw(12'h796);
      acc(1'b0, i2cis_pkg::OFF_DATA, 32'h0);
      `CHK(q[7:0], 8'h5A)
   endtask : t_rxover
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_fifo();
      t_gcall();
      t_rdreq();
      t_rxover();
      summarize();
   end
endmodule : i2cis_core_tb
bind i2cis_core i2cis_core_sva #(.DEPTH(DEPTH)) u_sva (.clk_i, .resetn_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
   .pslverr_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);

/* testbench/i2cis_master_bfm.sv */
// Remote two-wire master model on open-drain pins
`timescale 1ns/1ps
module i2cis_master_bfm (
   // Bus pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_oe_o,
   output logic      sda_oe_o
);
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   // Data set while clock low, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o = !b;
      #80;
      scl_oe_o = 1'b0;
      wait (scl_i);
      #80;
      r = sda_i;
      scl_oe_o = 1'b1;
   endtask : bit_io
   task automatic start_c();
      sda_oe_o = 1'b1;
      #80;
      scl_oe_o = 1'b1;
   endtask : start_c
   task automatic stop_c();
      sda_oe_o = 1'b1;
      #80;
      scl_oe_o = 1'b0;
      #80;
      sda_oe_o = 1'b0;
   endtask : stop_c
   // Ninth bit released, so a read byte always ends in no-acknowledge
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : xfer
endmodule : i2cis_master_bfm
